// file: logic/ar_timer.sv
// Overview of operation
// - eight-bit up counter advances on each prescaler output tick
// - two-bit source field picks internal, internal divided by three, or input pin
// - seven-bit prescaler, tap select gives division by one up to 128
// - count enable low freezes prescaler and counter, high lets them count
// - reset clears the counter to zero
// - load register write copies into counter at once; reads return live count
// - every counter load also clears the prescaler
// - auto-reload mode reloads counter on overflow and drives output high
// - compare match drives output low, sets compare flag, may interrupt
// - overflow sets overflow flag, requests interrupt when enabled
// - capture modes copy counter into reload register on active edge, set flag
// - capture and load modes run free with overflow high, compare low
// - capture with reset also clears counter and prescaler
// - external load mode copies reload register into counter on active edge
// - writing 06h to flags clears only overflow, keeps edge flag
// - request arising during service is held and presented after exit
// - mode field: 00 reload, 01 capture, 10 capture reset, 11 edge load
// - source field: 00 internal, 01 divided by three, 10 pin, 11 reserved
// - edge enable off disables detection; polarity zero rising, one falling
// - writing zero clears a flag bit, writing one leaves it alone
module ar_timer #(
	parameter int COUNT_W    = 8,
	parameter int PRESCALE_W = 7
) (
	input  wire logic                clock,
	input  wire logic                arst_n,
	input  wire logic                timer_input_pin,
	output logic                     timer_output_pin,
	input  wire logic [1:0]          mode_sel,
	input  wire logic                count_enable,
	input  wire logic                pwm_output_enable,
	input  wire logic                overflow_irq_enable,
	input  wire logic                compare_irq_enable,
	input  wire logic                external_irq_enable,
	input  wire logic                counter_load_bit,
	input  wire logic [1:0]          clock_source_sel,
	input  wire logic                edge_detect_enable,
	input  wire logic                edge_polarity_sel,
	input  wire logic [2:0]          prescale_tap_field,
	input  wire logic                reload_wr,
	input  wire logic [COUNT_W-1:0]  reload_wdata,
	output logic [COUNT_W-1:0]       reload_capture_reg,
	input  wire logic                compare_wr,
	input  wire logic [COUNT_W-1:0]  compare_wdata,
	output logic [COUNT_W-1:0]       compare_value_reg,
	input  wire logic                load_wr,
	input  wire logic [COUNT_W-1:0]  load_wdata,
	output logic [COUNT_W-1:0]       on_the_fly_load_reg,
	input  wire logic                flag_wr,
	input  wire logic [2:0]          flag_wdata,
	output logic [2:0]               flag_status_reg,
	input  wire logic                irq_service_active,
	output logic                     irq_request
);
	// counter and prescaler logic is written for these widths only
	if (COUNT_W != 8 || PRESCALE_W != 7) begin
		$error("ar_timer supports only an 8-bit counter and 7-bit prescaler");
	end

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n_r;

	// two-flop release of the asynchronous reset
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// pin edge detection
	// ----------------------------------------------------------------
	logic pin_rise;
	logic pin_fall;

	edge_sync u_edge_sync (
		.clock    (clock),
		.rst_n    (rst_n_r),
		.async_in (timer_input_pin),
		.rise     (pin_rise),
		.fall     (pin_fall)
	);

	logic active_edge;
	// polarity picks the edge, enable gates it
	assign active_edge = edge_detect_enable
		& (edge_polarity_sel ? pin_fall : pin_rise);

	// ----------------------------------------------------------------
	// counter state
	// ----------------------------------------------------------------
	logic [1:0]            div3_r;
	logic [1:0]            div3_nxt;
	logic [PRESCALE_W-1:0] presc_r;
	logic [PRESCALE_W-1:0] presc_nxt;
	logic [COUNT_W-1:0]    cnt_r;
	logic [COUNT_W-1:0]    cnt_nxt;
	logic [COUNT_W-1:0]    reload_r;
	logic [COUNT_W-1:0]    reload_nxt;
	logic [COUNT_W-1:0]    cmp_r;
	logic [COUNT_W-1:0]    cmp_nxt;
	logic                  out_r;
	logic                  out_nxt;
	logic [2:0]            flag_r;
	logic [2:0]            flag_nxt;
	logic [2:0]            pend_r;
	logic [2:0]            pend_nxt;
	logic                  irq_r;
	logic                  irq_nxt;
	logic                  src_tick;
	logic                  tick;
	logic                  ovf_ev;
	logic                  cmp_ev;
	logic                  cap_ev;
	logic [2:0]            set_ev;
	logic [2:0]            raw_req;
	logic                  load_ev;
	logic [2:0]            irq_en;

	// tap n divides the source by two to the n
	function automatic logic tap_hit(input logic [PRESCALE_W-1:0] p, input logic [2:0] n);
		logic [PRESCALE_W-1:0] mask;
		mask = PRESCALE_W'((8'h01 << n) - 8'h01);
		return (p & mask) == mask;
	endfunction

	// source tick and prescaler output tick
	always_comb begin
		unique case (clock_source_sel)
			ar_timer_pkg::CLK_INT:      src_tick = 1'b1;
			ar_timer_pkg::CLK_INT_DIV3: src_tick = (div3_r == ar_timer_pkg::DIV3_LAST);
			ar_timer_pkg::CLK_EXT_PIN:  src_tick = pin_rise;
			default:                    src_tick = 1'b0;
		endcase
		tick = count_enable & src_tick & tap_hit(presc_r, prescale_tap_field);
	end

	// counting, loading, capture and output
	always_comb begin
		div3_nxt   = div3_r;
		presc_nxt  = presc_r;
		cnt_nxt    = cnt_r;
		reload_nxt = reload_r;
		cmp_nxt    = cmp_r;
		out_nxt    = out_r;
		ovf_ev     = 1'b0;
		cmp_ev     = 1'b0;
		cap_ev     = 1'b0;
		if (compare_wr) begin
			cmp_nxt = compare_wdata;
		end
		if (reload_wr) begin
			reload_nxt = reload_wdata;
		end
		// frozen while disabled
		if (count_enable) begin
			div3_nxt = (div3_r == ar_timer_pkg::DIV3_LAST) ?
				ar_timer_pkg::DIV3_RESET : div3_r + 2'h1;
			if (src_tick) begin
				presc_nxt = presc_r + 7'h01;
			end
		end
		if (tick) begin
			if (cnt_r == ar_timer_pkg::COUNTER_MAX) begin
				ovf_ev  = 1'b1;
				out_nxt = 1'b1;
				if (mode_sel == ar_timer_pkg::MODE_AUTO_RELOAD) begin
					cnt_nxt   = reload_r;
					presc_nxt = ar_timer_pkg::PRESCALE_RESET;
				end else begin
					cnt_nxt = ar_timer_pkg::COUNTER_RESET;
				end
			end else begin
				cnt_nxt = cnt_r + 8'h01;
			end
		end
		// compare match on the count value being stepped to (cnt_nxt), not the current cnt_r
		if (tick && cnt_nxt == cmp_r) begin
			cmp_ev  = 1'b1;
			out_nxt = 1'b0;
		end
		if (active_edge) begin
			unique case (mode_sel)
				ar_timer_pkg::MODE_CAPTURE: begin
					cap_ev     = 1'b1;
					reload_nxt = cnt_r;
				end
				ar_timer_pkg::MODE_CAPTURE_RST: begin
					cap_ev     = 1'b1;
					reload_nxt = cnt_r;
					cnt_nxt    = ar_timer_pkg::COUNTER_RESET;
					presc_nxt  = ar_timer_pkg::PRESCALE_RESET;
				end
				ar_timer_pkg::MODE_EXT_LOAD: begin
					cnt_nxt   = reload_r;
					presc_nxt = ar_timer_pkg::PRESCALE_RESET;
				end
				ar_timer_pkg::MODE_AUTO_RELOAD: begin
				end
			endcase
		end
		// software loads win over counting
		if (counter_load_bit) begin
			cnt_nxt   = reload_r;
			presc_nxt = ar_timer_pkg::PRESCALE_RESET;
		end
		if (load_wr) begin
			cnt_nxt   = load_wdata;
			presc_nxt = ar_timer_pkg::PRESCALE_RESET;
		end
	end

	// ----------------------------------------------------------------
	// flags and interrupt request
	// ----------------------------------------------------------------
	// external-load edges raise the edge flag as captures do
	assign load_ev = active_edge & (mode_sel == ar_timer_pkg::MODE_EXT_LOAD);

	// flag events and enables placed at their bit positions
	always_comb begin
		set_ev = ar_timer_pkg::FLAG_RESET;
		irq_en = ar_timer_pkg::FLAG_RESET;
		set_ev[ar_timer_pkg::FLAG_OVF_BIT] = ovf_ev;
		set_ev[ar_timer_pkg::FLAG_CPF_BIT] = cmp_ev;
		set_ev[ar_timer_pkg::FLAG_EF_BIT]  = cap_ev | load_ev;
		irq_en[ar_timer_pkg::FLAG_OVF_BIT] = overflow_irq_enable;
		irq_en[ar_timer_pkg::FLAG_CPF_BIT] = compare_irq_enable;
		irq_en[ar_timer_pkg::FLAG_EF_BIT]  = external_irq_enable;
	end

	// write zero clears, write one keeps, set beats clear
	always_comb begin
		flag_nxt = flag_r;
		if (flag_wr) begin
			flag_nxt = flag_r & flag_wdata;
		end
		flag_nxt = flag_nxt | set_ev;
		raw_req  = flag_nxt & irq_en;
		// new requests during service are held until it ends
		pend_nxt = pend_r | (set_ev & raw_req);
		if (irq_service_active) begin
			irq_nxt = irq_r;
		end else begin
			irq_nxt  = (|raw_req) | (|pend_r);
			pend_nxt = set_ev & raw_req;
		end
	end

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			div3_r   <= ar_timer_pkg::DIV3_RESET;
			presc_r  <= ar_timer_pkg::PRESCALE_RESET;
			cnt_r    <= ar_timer_pkg::COUNTER_RESET;
			reload_r <= ar_timer_pkg::RELOAD_RESET;
			cmp_r    <= ar_timer_pkg::RELOAD_RESET;
			out_r    <= 1'b0;
			flag_r   <= ar_timer_pkg::FLAG_RESET;
			pend_r   <= ar_timer_pkg::FLAG_RESET;
			irq_r    <= 1'b0;
		end else begin
			div3_r   <= div3_nxt;
			presc_r  <= presc_nxt;
			cnt_r    <= cnt_nxt;
			reload_r <= reload_nxt;
			cmp_r    <= cmp_nxt;
			out_r    <= out_nxt;
			flag_r   <= flag_nxt;
			pend_r   <= pend_nxt;
			irq_r    <= irq_nxt;
		end
	end

	// registered pin output gated by pwm enable
	logic pin_r;
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pin_r <= 1'b0;
		end else begin
			pin_r <= out_nxt & pwm_output_enable;
		end
	end

	assign timer_output_pin    = pin_r;
	assign reload_capture_reg  = reload_r;
	assign compare_value_reg   = cmp_r;
	assign on_the_fly_load_reg = cnt_r;
	assign flag_status_reg     = flag_r;
	assign irq_request         = irq_r;
endmodule

// file: logic/ar_timer_pkg.sv
package ar_timer_pkg;

	// ----------------------------------------------------------------
	// operating modes
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_AUTO_RELOAD = 2'h0;
	localparam logic [1:0] MODE_CAPTURE     = 2'h1;
	localparam logic [1:0] MODE_CAPTURE_RST = 2'h2;
	localparam logic [1:0] MODE_EXT_LOAD    = 2'h3;

	// ----------------------------------------------------------------
	// clock sources
	// ----------------------------------------------------------------
	localparam logic [1:0] CLK_INT      = 2'h0;
	localparam logic [1:0] CLK_INT_DIV3 = 2'h1;
	localparam logic [1:0] CLK_EXT_PIN  = 2'h2;

	// ----------------------------------------------------------------
	// flag bit positions, reset values and end values
	// ----------------------------------------------------------------
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CPF_BIT = 1;
	localparam int FLAG_EF_BIT  = 2;
	localparam logic [7:0] COUNTER_RESET   = 8'h00;
	localparam logic [6:0] PRESCALE_RESET  = 7'h00;
	localparam logic [1:0] DIV3_RESET      = 2'h0;
	localparam logic [1:0] DIV3_LAST       = 2'h2;
	localparam logic [7:0] RELOAD_RESET    = 8'h00;
	localparam logic [7:0] COUNTER_MAX     = 8'hff;
	localparam logic [2:0] FLAG_RESET      = 3'h0;

endpackage

// file: logic/edge_sync.sv
// ----------------------------------------------------------------
// two-flop synchroniser with rising and falling edge pulses
// ----------------------------------------------------------------
module edge_sync (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic async_in,
	output logic      rise,
	output logic      fall
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	// meta_r is read only by sync_r
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	// one pulse per settled transition
	assign rise = sync_r & ~last_r;
	assign fall = ~sync_r & last_r;
endmodule

// file: tb/ar_timer_properties.sv
// ----------------------------------------------------------------
// port checker for the timer
// ----------------------------------------------------------------
module ar_timer_properties #(
	parameter int COUNT_W = 8
) (
	input wire logic               clock,
	input wire logic               arst_n,
	input wire logic               timer_output_pin,
	input wire logic [1:0]         mode_sel,
	input wire logic               count_enable,
	input wire logic               counter_load_bit,
	input wire logic [1:0]         clock_source_sel,
	input wire logic               edge_detect_enable,
	input wire logic [2:0]         prescale_tap_field,
	input wire logic [COUNT_W-1:0] reload_capture_reg,
	input wire logic [COUNT_W-1:0] compare_value_reg,
	input wire logic               load_wr,
	input wire logic [COUNT_W-1:0] load_wdata,
	input wire logic [COUNT_W-1:0] on_the_fly_load_reg,
	input wire logic               flag_wr,
	input wire logic [2:0]         flag_wdata,
	input wire logic [2:0]         flag_status_reg
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic fast;
	// counting on every clock, nothing else moving the counter
	assign fast = count_enable && clock_source_sel == 2'h0 && prescale_tap_field == 3'h0
		&& !load_wr && !counter_load_bit && !edge_detect_enable;
	sequence at_top;
		fast && on_the_fly_load_reg == 8'hff;
	endsequence
	sequence below_top;
		fast && on_the_fly_load_reg != 8'hff;
	endsequence
	AST_LOAD_WRITE: assert property (
		load_wr |=> on_the_fly_load_reg == $past(load_wdata))
		else $error("load write not copied");
	AST_FREEZE: assert property (
		!count_enable && !load_wr && !counter_load_bit && !edge_detect_enable
		|=> $stable(on_the_fly_load_reg)) else $error("stopped counter moved");
	AST_LOAD_BIT: assert property (
		counter_load_bit && !load_wr |=> on_the_fly_load_reg == $past(reload_capture_reg))
		else $error("load bit did not copy reload");
	AST_OVF_HOLD: assert property (
		flag_status_reg[0] && !(flag_wr && !flag_wdata[0]) |=> flag_status_reg[0])
		else $error("overflow flag lost");
	AST_CLEAR_06: assert property (
		flag_wr && flag_wdata == 3'h6 && !count_enable
		|=> !flag_status_reg[0] && (flag_status_reg[2] || !$past(flag_status_reg[2])))
		else $error("flag write 06 wrong");
	AST_RELOAD: assert property (
		at_top and mode_sel == ar_timer_pkg::MODE_AUTO_RELOAD
		|=> on_the_fly_load_reg == $past(reload_capture_reg) && flag_status_reg[0])
		else $error("overflow did not reload");
	AST_WRAP: assert property (
		at_top and mode_sel != ar_timer_pkg::MODE_AUTO_RELOAD
		|=> on_the_fly_load_reg == 8'h00 && flag_status_reg[0]) else $error("no wrap");
	AST_STEP: assert property (
		below_top |=> on_the_fly_load_reg == $past(on_the_fly_load_reg) + 8'h01)
		else $error("counter step wrong");
	AST_COMPARE: assert property (
		below_top and on_the_fly_load_reg + 8'h01 == compare_value_reg
		|=> !timer_output_pin && flag_status_reg[1]) else $error("compare missed");
endmodule

bind ar_timer ar_timer_properties #(.COUNT_W(COUNT_W)) checker_i (.*);

// file: tb/auto_reload_pwm_capture_timer_tb.sv
// ----------------------------------------------------------------
// directed bench for the timer
// ----------------------------------------------------------------
module auto_reload_pwm_capture_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clock, arst_n, timer_input_pin, timer_output_pin, drive_level, count_enable;
	logic       pwm_output_enable, overflow_irq_enable, compare_irq_enable, external_irq_enable;
	logic       counter_load_bit, edge_detect_enable, edge_polarity_sel, reload_wr, compare_wr;
	logic       load_wr, flag_wr, irq_service_active, irq_request;
	logic [1:0] mode_sel, clock_source_sel;
	logic [2:0] prescale_tap_field, flag_wdata, flag_status_reg;
	logic [7:0] reload_wdata, reload_capture_reg, compare_wdata, compare_value_reg;
	logic [7:0] load_wdata, on_the_fly_load_reg;
	int         fail_count = 0, total_checks = 0, cycles = 0;
	ar_timer dut (.*);
	pin_source src (.*);
	// free running clock
	initial clock = 1'b0;
	always #4 clock = ~clock;
	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic pulse(ref logic strobe);
		strobe = 1'b1;
		tick(1);
		strobe = 1'b0;
	endtask
	task automatic wr(ref logic strobe, ref logic [7:0] data, input logic [7:0] v);
		data = v;
		pulse(strobe);
	endtask
	task automatic restart(input logic [1:0] src_sel, input logic [2:0] tap);
		count_enable = 1'b0;
		clock_source_sel = src_sel;
		prescale_tap_field = tap;
		wr(load_wr, load_wdata, 8'h00);
		count_enable = 1'b1;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// main sequence
	initial begin
		{drive_level, count_enable, pwm_output_enable, overflow_irq_enable} = '0;
		{compare_irq_enable, external_irq_enable, counter_load_bit, edge_detect_enable} = '0;
		{edge_polarity_sel, reload_wr, compare_wr, load_wr, flag_wr, irq_service_active} = '0;
		{mode_sel, clock_source_sel, prescale_tap_field, flag_wdata} = '0;
		{reload_wdata, compare_wdata, load_wdata} = '0;
		arst_n = 1'b0;
		tick(8);
		arst_n = 1'b1;
		tick(3);
		check("reset count", on_the_fly_load_reg, 8'h00);
		wr(load_wr, load_wdata, 8'h5a);
		check("load write", on_the_fly_load_reg, 8'h5a);
		tick(5);
		check("frozen count", on_the_fly_load_reg, 8'h5a);
		wr(reload_wr, reload_wdata, 8'hf0);
		wr(compare_wr, compare_wdata, 8'hf8);
		check("compare reg", compare_value_reg, 8'hf8);
		pulse(counter_load_bit);
		check("load bit", on_the_fly_load_reg, 8'hf0);
		{pwm_output_enable, overflow_irq_enable, count_enable} = 3'h7;
		tick(8);
		check("compare pin", {7'h0, timer_output_pin}, 8'h00);
		check("compare flag", {7'h0, flag_status_reg[1]}, 8'h01);
		tick(8);
		check("reloaded", on_the_fly_load_reg, 8'hf0);
		check("overflow pin", {7'h0, timer_output_pin}, 8'h01);
		tick(2);
		check("overflow irq", {7'h0, irq_request}, 8'h01);
		tick(6);
		check("pwm low again", {7'h0, timer_output_pin}, 8'h00);
		count_enable = 1'b0;
		mode_sel = 2'h1;
		edge_detect_enable = 1'b1;
		wr(load_wr, load_wdata, 8'h33);
		drive_level = 1'b1;
		tick(5);
		check("rising capture", reload_capture_reg, 8'h33);
		check("flags", {5'h0, flag_status_reg}, 8'h07);
		edge_polarity_sel = 1'b1;
		wr(load_wr, load_wdata, 8'h44);
		drive_level = 1'b0;
		tick(5);
		check("falling capture", reload_capture_reg, 8'h44);
		wr(load_wr, load_wdata, 8'h55);
		drive_level = 1'b1;
		tick(5);
		check("wrong edge", reload_capture_reg, 8'h44);
		edge_detect_enable = 1'b0;
		drive_level = 1'b0;
		tick(5);
		check("edges off", reload_capture_reg, 8'h44);
		flag_wdata = 3'h6;
		pulse(flag_wr);
		check("flags after 06", {5'h0, flag_status_reg}, 8'h06);
		flag_wdata = 3'h0;
		tick(1);
		pulse(flag_wr);
		check("flags cleared", {5'h0, flag_status_reg}, 8'h00);
		mode_sel = 2'h2;
		{edge_detect_enable, edge_polarity_sel} = 2'h2;
		wr(load_wr, load_wdata, 8'h21);
		drive_level = 1'b1;
		tick(5);
		check("period capture", reload_capture_reg, 8'h21);
		check("count restart", on_the_fly_load_reg, 8'h00);
		mode_sel = 2'h3;
		edge_polarity_sel = 1'b1;
		wr(reload_wr, reload_wdata, 8'h7c);
		drive_level = 1'b0;
		tick(5);
		check("edge load", on_the_fly_load_reg, 8'h7c);
		edge_detect_enable = 1'b0;
		wr(load_wr, load_wdata, 8'hfe);
		count_enable = 1'b1;
		tick(2);
		check("wrap", on_the_fly_load_reg, 8'h00);
		check("wrap flags", {5'h0, flag_status_reg}, 8'h05);
		restart(2'h0, 3'h3);
		tick(20);
		check("divide by 8", on_the_fly_load_reg, 8'h02);
		restart(2'h1, 3'h0);
		tick(30);
		check("divide by 3", on_the_fly_load_reg, 8'h0a);
		mode_sel = 2'h0;
		restart(2'h2, 3'h0);
		repeat (3) begin
			drive_level = 1'b1;
			tick(4);
			drive_level = 1'b0;
			tick(4);
		end
		check("pin clock", on_the_fly_load_reg, 8'h03);
		clock_source_sel = 2'h3;
		tick(10);
		check("reserved source", on_the_fly_load_reg, 8'h03);
		// edge event during service is held and shown after exit
		{count_enable, overflow_irq_enable, external_irq_enable} = 3'h1;
		{mode_sel, edge_detect_enable, edge_polarity_sel} = 4'h6;
		flag_wdata = 3'h0;
		pulse(flag_wr);
		check("irq idle", {7'h0, irq_request}, 8'h00);
		irq_service_active = 1'b1;
		drive_level = 1'b1;
		tick(5);
		check("irq held", {7'h0, irq_request}, 8'h00);
		check("service capture", reload_capture_reg, 8'h03);
		flag_wdata = 3'h3;
		pulse(flag_wr);
		check("edge flag cleared", {5'h0, flag_status_reg}, 8'h00);
		irq_service_active = 1'b0;
		tick(1);
		check("latched irq", {7'h0, irq_request}, 8'h01);
		tick(1);
		check("latched irq ends", {7'h0, irq_request}, 8'h00);
		report_and_stop();
	end
endmodule

// file: tb/pin_source.sv
// ----------------------------------------------------------------
// external signal source on the input pin
// ----------------------------------------------------------------
module pin_source (
	input  wire logic drive_level,
	output logic      timer_input_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// pin follows the command with a skew unrelated to the clock
	initial timer_input_pin = 1'b0;
	always @(drive_level) begin
		timer_input_pin <= #3 drive_level;
	end
endmodule
